// ### rtl/cag_pkg.sv
package cag_pkg;

    localparam int ADDR_W = 32;
    localparam int REG_IDX_W = 5;
    localparam int BK_W = 5;

    // Mode register layout: two bits per eligible pointer, block-size fields above
    localparam int MODE_FIELD_W = 2;
    localparam int MODE_PTR_BASE_B = 8;
    localparam int BK_ZERO_LSB = 16;
    localparam int BK_ONE_LSB = 21;

    localparam logic [1:0] MODE_LINEAR = 2'h0;
    localparam logic [1:0] MODE_CIRC_ZERO = 2'h1;
    localparam logic [1:0] MODE_CIRC_ONE = 2'h2;

    localparam logic [REG_IDX_W-1:0] PTR_FIRST = 5'h04;
    localparam logic [REG_IDX_W-1:0] PTR_LAST = 5'h07;
    localparam logic [REG_IDX_W-1:0] LONG_BASE_LO = 5'h0E;
    localparam logic [REG_IDX_W-1:0] LONG_BASE_HI = 5'h0F;

    localparam int SHORT_OFF_W = 5;
    localparam int LONG_OFF_W = 15;

    typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD} cag_size_t;

    typedef enum logic [2:0] {
        OP_LOAD_STORE,
        OP_ADDR_ADD,
        OP_ADDR_SUB,
        OP_OTHER_UNIT
    } cag_op_t;

    typedef enum logic [2:0] {
        AM_PLUS_OFFSET,
        AM_MINUS_OFFSET,
        AM_PRE_INC,
        AM_PRE_DEC,
        AM_POST_INC,
        AM_POST_DEC
    } cag_amode_t;

    typedef enum logic [1:0] {OFF_REGISTER, OFF_SHORT, OFF_LONG} cag_offkind_t;

    typedef struct packed {
        logic valid;
        logic unitTwo;
        cag_op_t op;
        cag_size_t size;
        cag_amode_t amode;
        cag_offkind_t offKind;
        logic [REG_IDX_W-1:0] ptrIdx;
        logic [ADDR_W-1:0] basePointer;
        logic [ADDR_W-1:0] offsetValue;
    } cag_req_t;

    typedef struct packed {
        logic valid;
        logic illegal;
        logic circular;
        logic [ADDR_W-1:0] effAddr;
        logic writeBack;
        logic [ADDR_W-1:0] ptrNew;
    } cag_rsp_t;

endpackage : cag_pkg

// ### rtl/circular_address_generator.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module circular_address_generator
    import cag_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Addressing mode register contents
    input wire logic [ADDR_W-1:0] addressModeRegister,
    // Requests from data unit one and data unit two
    input cag_req_t dataUnitOneReq,
    input cag_req_t dataUnitTwoReq,
    // Results, one cycle later
    output cag_rsp_t dataUnitOneRsp,
    output cag_rsp_t dataUnitTwoRsp
);

    //////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] ptr_mode(input logic [ADDR_W-1:0] address_mode_register, input logic unitTwo,
                                            input logic [REG_IDX_W-1:0] idx, input cag_op_t op);
        logic [1:0] m;
        int pos;
        m = MODE_LINEAR;
        pos = 0;
        if (op != OP_OTHER_UNIT && idx >= PTR_FIRST && idx <= PTR_LAST)
        begin
            pos = (unitTwo ? MODE_PTR_BASE_B : 0) + MODE_FIELD_W * int'(idx - PTR_FIRST);
            m = address_mode_register[pos +: MODE_FIELD_W];
        end
        return m;
    endfunction : ptr_mode

    function automatic logic [ADDR_W-1:0] circ_mask(input logic [BK_W-1:0] n);
        logic [ADDR_W:0] full;
        full = '0;
        // Buffer of 2^(N+1) bytes, unscaled by access size
        full[int'(n) + 1] = 1'b1;
        return full[ADDR_W-1:0] - 32'h00000001;
    endfunction : circ_mask

    function automatic cag_rsp_t compute(input cag_req_t r, input logic [ADDR_W-1:0] address_mode_register);
        cag_rsp_t o;
        logic [1:0] mode;
        logic [BK_W-1:0] bk;
        logic [ADDR_W-1:0] mask;
        logic [ADDR_W-1:0] off;
        logic [ADDR_W-1:0] scaled;
        logic [ADDR_W-1:0] raw;
        logic [ADDR_W-1:0] updated;
        logic subtract;
        o = '0;
        mode = ptr_mode(address_mode_register, r.unitTwo, r.ptrIdx, r.op);
        bk = (mode == MODE_CIRC_ONE) ? address_mode_register[BK_ONE_LSB +: BK_W] : address_mode_register[BK_ZERO_LSB +: BK_W];
        mask = (mode == MODE_LINEAR) ? '1 : circ_mask(bk);
        case (r.offKind)
            OFF_SHORT: off = {{(ADDR_W-SHORT_OFF_W){1'b0}}, r.offsetValue[SHORT_OFF_W-1:0]};
            OFF_LONG: off = {{(ADDR_W-LONG_OFF_W){1'b0}}, r.offsetValue[LONG_OFF_W-1:0]};
            default: off = r.offsetValue;
        endcase
        case (r.size)
            SIZE_WORD: scaled = off << 2;
            SIZE_HALF: scaled = off << 1;
            default: scaled = off;
        endcase
        subtract = (r.op == OP_ADDR_SUB) || (r.amode == AM_MINUS_OFFSET) ||
                   (r.amode == AM_PRE_DEC) || (r.amode == AM_POST_DEC);
        raw = subtract ? r.basePointer - scaled : r.basePointer + scaled;
        // Low bits wrap, upper bits held from the base
        updated = (raw & mask) | (r.basePointer & ~mask);
        o.valid = r.valid;
        o.circular = (mode != MODE_LINEAR);
        o.illegal = (mode == MODE_CIRC_ONE + 2'h1);
        if (r.offKind == OFF_LONG && ((r.ptrIdx != LONG_BASE_LO && r.ptrIdx != LONG_BASE_HI) || !r.unitTwo ||
            (r.amode != AM_PLUS_OFFSET && r.amode != AM_MINUS_OFFSET)))
        begin
            o.illegal = 1'b1;
        end
        if (r.op == OP_LOAD_STORE)
        begin
            case (r.amode)
                AM_PRE_INC, AM_PRE_DEC:
                begin
                    o.effAddr = updated;
                    o.writeBack = 1'b1;
                    o.ptrNew = updated;
                end
                AM_POST_INC, AM_POST_DEC:
                begin
                    o.effAddr = r.basePointer;
                    o.writeBack = 1'b1;
                    o.ptrNew = updated;
                end
                default:
                begin
                    o.effAddr = updated;
                end
            endcase
        end
        else if (r.op == OP_OTHER_UNIT)
        begin
            o.effAddr = raw;
        end
        else
        begin
            o.effAddr = updated;
        end
        if (o.illegal)
        begin
            o.writeBack = 1'b0;
        end
        return o;
    endfunction : compute

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dataUnitOneRsp <= '0;
        end
        else
        begin
            dataUnitOneRsp <= compute(dataUnitOneReq, addressModeRegister);
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dataUnitTwoRsp <= '0;
        end
        else
        begin
            dataUnitTwoRsp <= compute(dataUnitTwoReq, addressModeRegister);
        end
    end

endmodule : circular_address_generator

// ### bench/cag_properties.sv
`timescale 1ns/1ps
module cag_properties
    import cag_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Watched ports
    input wire logic [ADDR_W-1:0] addressModeRegister,
    input cag_req_t dataUnitOneReq,
    input cag_req_t dataUnitTwoReq,
    input cag_rsp_t dataUnitOneRsp,
    input cag_rsp_t dataUnitTwoRsp
);
    cag_req_t q1, q2;
    cag_rsp_t p1, p2;
    assign q1 = dataUnitOneReq;
    assign q2 = dataUnitTwoReq;
    assign p1 = dataUnitOneRsp;
    assign p2 = dataUnitTwoRsp;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    valid_one_a: assert property (1 |=> p1.valid == $past(q1.valid))
        else $error("unit one valid lost");
    valid_two_a: assert property (1 |=> p2.valid == $past(q2.valid))
        else $error("unit two valid lost");
    low_ptr_a: assert property (q1.valid && q1.ptrIdx < PTR_FIRST |=> !p1.circular)
        else $error("ineligible pointer went circular");
    other_unit_a: assert property (q1.valid && q1.op == OP_OTHER_UNIT |=> !p1.circular)
        else $error("other unit went circular");
    post_addr_a: assert property (q1.valid && q1.amode == AM_POST_INC && q1.offKind != OFF_LONG
        |=> p1.effAddr == $past(q1.basePointer) && p1.writeBack) else $error("post form address wrong");
    pre_addr_a: assert property (q1.valid && q1.amode == AM_PRE_DEC |=> p1.effAddr == p1.ptrNew)
        else $error("pre form address wrong");
    plain_nowb_a: assert property (q2.valid && q2.amode == AM_MINUS_OFFSET |=> !p2.writeBack)
        else $error("plain form wrote back");
    long_pre_a: assert property (q2.valid && q2.offKind == OFF_LONG && q2.amode == AM_PRE_INC
        |=> p2.illegal && !p2.writeBack) else $error("long offset pre form accepted");
endmodule : cag_properties
bind circular_address_generator cag_properties chk (.core_clk, .rstn, .addressModeRegister,
    .dataUnitOneReq, .dataUnitTwoReq, .dataUnitOneRsp, .dataUnitTwoRsp);

// ### bench/cag_core_model.sv
`timescale 1ns/1ps
module cag_core_model
    import cag_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Mode register and requests
    output logic [ADDR_W-1:0] modeReg,
    output cag_req_t oneReq,
    output cag_req_t twoReq
);
    initial
    begin
        modeReg = '0;
        oneReq = '0;
        twoReq = '0;
    end
    // One request, then the lines turn to garbage with valid low
    task issue(logic [31:0] m, logic u, cag_req_t r);
        r.unitTwo = u;
        @(posedge core_clk);
        modeReg <= m;
        if (u) twoReq <= r; else oneReq <= r;
        @(posedge core_clk);
        r = cag_req_t'(~r);
        r.valid = 1'b0;
        if (u) twoReq <= r; else oneReq <= r;
    endtask : issue
endmodule : cag_core_model

// ### bench/circular_address_generator_bench.sv
`timescale 1ns/1ps
module circular_address_generator_bench
    import cag_pkg::*;
;
    logic coreClk, rstN;
    logic [ADDR_W-1:0] modeReg;
    cag_req_t oneReq, twoReq;
    cag_rsp_t oneRsp, twoRsp, s;
    int errCount = 0, checksDone = 0, cycles = 0;
    circular_address_generator uut (.core_clk(coreClk), .rstn(rstN), .addressModeRegister(modeReg),
        .dataUnitOneReq(oneReq), .dataUnitTwoReq(twoReq), .dataUnitOneRsp(oneRsp), .dataUnitTwoRsp(twoRsp));
    cag_core_model core (.core_clk(coreClk), .modeReg(modeReg), .oneReq(oneReq), .twoReq(twoReq));
    //////////////////////////////////////////////////////////////
    function automatic cag_req_t mk(logic [4:0] i, logic [31:0] b, f, cag_op_t o = OP_LOAD_STORE,
        cag_size_t z = SIZE_WORD, cag_amode_t a = AM_PLUS_OFFSET, cag_offkind_t k = OFF_REGISTER);
        mk = '{1'b1, 1'b0, o, z, a, k, i, b, f};
    endfunction : mk
    task chk(logic [31:0] seen, exp);
        checksDone++;
        if (seen !== exp) begin errCount++; $display("Error %0t: got %h want %h", $time, seen, exp); end
    endtask : chk
    task xfer(logic [31:0] m, logic u, cag_req_t r, logic [31:0] eff, nw, logic wb);
        core.issue(m, u, r);
        #1 s = u ? twoRsp : oneRsp;
        chk(s.valid, 1);
        chk(s.effAddr, eff);
        chk(s.writeBack, wb);
        if (wb) chk(s.ptrNew, nw);
    endtask : xfer
    task summarize;
        if (errCount == 0 && checksDone > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    //////////////////////////////////////////////////////////////
    task linearSizes;
        xfer(0, 0, mk(0, 32'h100, 3, , SIZE_BYTE), 32'h103, 0, 0);
        xfer(0, 0, mk(0, 32'h100, 3, , SIZE_HALF), 32'h106, 0, 0);
        xfer(0, 0, mk(0, 32'h100, 3), 32'h10C, 0, 0);
        chk(s.circular, 0);
        xfer(0, 1, mk(4, 32'h100, 32'hFFFFFFE1, OP_ADDR_SUB, , , OFF_SHORT), 32'hFC, 0, 0);
    endtask : linearSizes
    task circularWord;
        xfer(32'h40001, 0, mk(4, 32'h100, 9), 32'h104, 0, 0);
        chk(s.circular, 1);
        xfer(32'h40001, 0, mk(4, 32'h100, 32'h24, , SIZE_BYTE), 32'h104, 0, 0);
    endtask : circularWord
    task scaledAdd;
        xfer(32'h20001, 0, mk(4, 32'h100, 32'hB, OP_ADDR_ADD, SIZE_BYTE), 32'h103, 0, 0);
        xfer(32'h20001, 0, mk(4, 32'h100, 32'hB, OP_ADDR_ADD, SIZE_HALF), 32'h106, 0, 0);
        xfer(32'h800200, 1, mk(4, 32'h100, 32'h13, OP_ADDR_SUB, SIZE_HALF), 32'h11A, 0, 0);
        chk(s.circular, 1);
    endtask : scaledAdd
    task modifyForms;
        xfer(32'h40001, 0, mk(4, 32'h11C, 1, , , AM_POST_INC), 32'h11C, 32'h100, 1);
        xfer(32'h40001, 0, mk(4, 32'h100, 1, , , AM_PRE_DEC), 32'h11C, 32'h11C, 1);
    endtask : modifyForms
    task longOffset;
        xfer(0, 1, mk(5'hE, 32'h8000, 32'hFFFF8001, , SIZE_BYTE, AM_MINUS_OFFSET, OFF_LONG), 32'h7FFF, 0, 0);
        xfer(0, 0, mk(5'hE, 0, 1, , SIZE_BYTE, , OFF_LONG), 1, 0, 0);
        chk(s.illegal, 1);
        core.issue(0, 1, mk(5'hF, 0, 1, , SIZE_BYTE, AM_PRE_INC, OFF_LONG));
        #1 chk(twoRsp.illegal, 1);
    endtask : longOffset
    task otherUnit;
        xfer(32'h40001, 0, mk(4, 32'h11C, 4, OP_OTHER_UNIT, SIZE_BYTE), 32'h120, 0, 0);
        chk(s.circular, 0);
        xfer(32'h45555, 1, mk(0, 32'h11C, 4, , SIZE_BYTE), 32'h120, 0, 0);
        chk(s.circular, 0);
    endtask : otherUnit
    //////////////////////////////////////////////////////////////
    initial
    begin
        coreClk = 1'b0;
        forever #25 coreClk = ~coreClk;
    end
    always @(posedge coreClk)
    begin
        cycles++;
        if (cycles == 500) begin errCount++; summarize(); end
    end
    initial
    begin
        rstN = 1'b0;
        repeat (10) @(posedge coreClk);
        rstN <= 1'b1;
        linearSizes();
        circularWord();
        scaledAdd();
        modifyForms();
        longOffset();
        otherUnit();
        summarize();
    end
endmodule : circular_address_generator_bench
